// file: hdl/hrs_pkg.sv
package hrs_pkg;
    localparam int CLK_MHZ = 125;
    localparam int RECOVERY_US = 500;
    localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
    localparam int INACTIVE_NS = 1500;
    localparam int INACTIVE_CYC = (INACTIVE_NS * CLK_MHZ) / 1000;
    localparam int EEPROM_MAX_US = 99500;
    localparam int EEPROM_MAX_CYC = EEPROM_MAX_US * CLK_MHZ;
    localparam int ATTACH_MAX_US = 100000;
    localparam int ATTACH_MAX_CYC = ATTACH_MAX_US * CLK_MHZ;
    localparam int REQ_MAX_US = 5000;
    localparam int REQ_MAX_CYC = REQ_MAX_US * CLK_MHZ;
    localparam logic [1:0] SRC_DEFAULT = 2'h0;
    localparam logic [1:0] SRC_STRAP = 2'h1;
    localparam logic [1:0] SRC_SMBUS = 2'h2;
    localparam logic [1:0] SRC_EEPROM = 2'h3;
    localparam logic [2:0] SEL_DEFAULT = 3'h0;
    localparam logic [2:0] SEL_STRAP = 3'h1;
    localparam logic [2:0] SEL_SMBUS = 3'h2;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam int NUM_PORTS = 4;
    localparam int LED_W = 8;
    typedef enum logic [2:0] {
        HRS_RESET    = 3'b000,
        HRS_RECOVER  = 3'b001,
        HRS_LOAD     = 3'b011,
        HRS_APPLY    = 3'b010,
        HRS_RUN      = 3'b110,
        HRS_TEST     = 3'b111
    } hrs_state_t;
endpackage

// file: hdl/hrs_sequencer.sv
// Summary of operation
// RULE1: Reset must be held at least 1us after supplies settle; outside party's duty.
// RULE2: During reset all downstream ports disabled and port power deasserted; code drives port power 0 in reset, on for a low polarity strap.
// RULE3: During reset transceivers disabled, differential pairs high impedance.
// RULE4: Reset aborts all transactions immediately, keeping no prior state.
// RULE5: Reset returns all internal registers to defaults, mostly zero.
// RULE6: During reset oscillator and PLL halted, LED outputs disabled.
// RULE7: Device becomes operational 500us after reset release.
// RULE8: Once operational, start EEPROM read unless SMBus option disabled.
// RULE9: Default or strap mode drives outputs inactive within 1.5us of release.
// RULE10: EEPROM read and apply finishes within 99.5ms.
// RULE11: SMBus host loads configuration within 99.5ms when bus powered.
// RULE12: Attach is signalled within 100ms after configuration completes.
// RULE13: Host waits 100ms after attach before bus reset; outside party's duty.
// RULE14: Each standard request completes within 5ms once running.
// RULE15: Bus reset sets address to zero and unconfigured state.
// RULE16: Bus reset deasserts power to downstream ports 4 to 1.
// RULE17: Bus reset empties all transaction translator buffers.
// RULE18: Bus reset while suspended returns device to active.
// RULE19: Bus reset is never forwarded to downstream ports.
// RULE20: Polarity strap picks port power level; strap low means active low.
// RULE21: Config select straps pick defaults, strapped defaults or SMBus load.
// RULE22: Test pin, select bit 1 high, clock low at release enter XNOR test.
// RULE23: Test mode drives XNOR chain result on the chain result pin.
// RULE24: Default mode samples LED pins after release as configuration straps.
// RULE25: Phases go reset, recovery, load, attach; never attach before load ends.
`timescale 1ns/1ns
module hrs_sequencer #(
    parameter int RECOVERY_CYC   = hrs_pkg::RECOVERY_CYC,
    parameter int EEPROM_MAX_CYC = hrs_pkg::EEPROM_MAX_CYC,
    parameter int ATTACH_MAX_CYC = hrs_pkg::ATTACH_MAX_CYC,
    parameter int REQ_MAX_CYC    = hrs_pkg::REQ_MAX_CYC,
    parameter int TEST_PINS      = 16
) (
    // Clock and reset.
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    // Straps and pins from outside.
    input  wire logic [2:0]                    cfg_sel_pin,
    input  wire logic                          port_power_polarity_strap,
    input  wire logic                          test_mode_pin,
    input  wire logic                          smb_clk_pin,
    input  wire logic                          smbus_disable,
    input  wire logic [hrs_pkg::LED_W-1:0]     led_pin,
    input  wire logic [TEST_PINS-1:0]          test_pins,
    // Configuration engine handshake.
    input  wire logic                          load_done,
    input  wire logic [hrs_pkg::NUM_PORTS-1:0] port_power_req,
    // Upstream bus events.
    input  wire logic                          bus_reset,
    input  wire logic                          suspend_req,
    input  wire logic                          req_start,
    input  wire logic                          req_done,
    // Status and controls out.
    output logic                               osc_enable,
    output logic                               pll_enable,
    output logic                               phy_enable,
    output logic                               led_enable,
    output logic                               outputs_driven,
    output logic [hrs_pkg::NUM_PORTS-1:0]      port_enable,
    output logic [hrs_pkg::NUM_PORTS-1:0]      port_power_out,
    output logic                               downstream_reset,
    output logic                               eeprom_read_start,
    output logic                               smbus_load_start,
    output logic [1:0]                         cfg_source,
    output logic [hrs_pkg::LED_W-1:0]          led_strap,
    output logic                               attach,
    output logic                               operational,
    output logic                               configured,
    output logic [6:0]                         dev_addr,
    output logic                               tt_flush,
    output logic                               suspended,
    output logic                               load_timeout,
    output logic                               req_timeout,
    output logic                               chain_result_out
);
    hrs_pkg::hrs_state_t state;
    hrs_pkg::hrs_state_t next_state;
    logic [31:0]                      count;
    logic [31:0]                      req_count;
    logic                             req_busy;
    logic [2:0]                       sel_s1, sel_s;
    logic                             pol_s1, pol_s, tst_s1, tst_s, sck_s1, sck_s;
    logic                             brst_s1, brst_s, susp_s1, susp_s, done_s1, done_s;
    logic [hrs_pkg::LED_W-1:0]        led_s1, led_s;
    logic [TEST_PINS-1:0]             tp_s1, tp_s;
    logic                             strap_taken;
    logic                             pol_high;

    // Every pin except smbus_disable, port_power_req, req_start and req_done passes two flip-flops before use.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {sel_s1, sel_s, pol_s1, pol_s, tst_s1, tst_s, sck_s1, sck_s} <= '0;
            {brst_s1, brst_s, susp_s1, susp_s, done_s1, done_s} <= '0;
            {led_s1, led_s, tp_s1, tp_s} <= '0;
        end else begin
            sel_s1  <= cfg_sel_pin;
            sel_s   <= sel_s1;
            pol_s1  <= port_power_polarity_strap;
            pol_s   <= pol_s1;
            tst_s1  <= test_mode_pin;
            tst_s   <= tst_s1;
            sck_s1  <= smb_clk_pin;
            sck_s   <= sck_s1;
            brst_s1 <= bus_reset;
            brst_s  <= brst_s1;
            susp_s1 <= suspend_req;
            susp_s  <= susp_s1;
            done_s1 <= load_done;
            done_s  <= done_s1;
            led_s1  <= led_pin;
            led_s   <= led_s1;
            tp_s1   <= test_pins;
            tp_s    <= tp_s1;
        end
    end

    wire recover_end = (count >= RECOVERY_CYC - 1);
    wire enter_test  = tst_s && sel_s[1] && !sck_s;
    wire use_eeprom  = !smbus_disable && (sel_s == hrs_pkg::SEL_SMBUS);
    wire use_smbus   = smbus_disable && (sel_s == hrs_pkg::SEL_SMBUS);
    wire is_default  = (sel_s != hrs_pkg::SEL_SMBUS);
    wire load_over   = done_s || is_default;
    wire load_expire = use_eeprom && (count >= EEPROM_MAX_CYC - 1);
    wire chain_xnor  = ~^tp_s;
    wire ports_on    = (state == hrs_pkg::HRS_RUN) && configured && !brst_s;
    wire [hrs_pkg::NUM_PORTS-1:0] pwr_active = ports_on ? port_power_req : '0;

    // Phase order: reset, recovery, load, apply, run; test is entered only from recovery, once the straps are caught.
    always_comb begin
        next_state = state;
        unique case (state)
            hrs_pkg::HRS_RESET:   next_state = hrs_pkg::HRS_RECOVER;
            hrs_pkg::HRS_RECOVER: begin
                if (!strap_taken) next_state = hrs_pkg::HRS_RECOVER;
                else if (enter_test) next_state = hrs_pkg::HRS_TEST; // [RULE22]
                else if (recover_end) next_state = hrs_pkg::HRS_LOAD; // [RULE7]
            end
            hrs_pkg::HRS_LOAD:    if (load_over || load_expire) next_state = hrs_pkg::HRS_APPLY; // [RULE25]
            hrs_pkg::HRS_APPLY:   next_state = hrs_pkg::HRS_RUN; // [RULE12]
            hrs_pkg::HRS_RUN:     next_state = hrs_pkg::HRS_RUN;
            hrs_pkg::HRS_TEST:    next_state = hrs_pkg::HRS_TEST;
            default:              next_state = hrs_pkg::HRS_RESET;
        endcase
    end

    // Reset clears every register to its default. [RULE4] [RULE5]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= hrs_pkg::HRS_RESET;
            count <= '0;
        end else begin
            state <= next_state;
            count <= (next_state != state) ? '0 : count + 32'd1;
        end
    end

    // Straps are caught once, in the cycles after release. [RULE20] [RULE21] [RULE24]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_taken <= 1'b0;
            pol_high    <= 1'b0;
            cfg_source  <= hrs_pkg::SRC_DEFAULT;
            led_strap   <= '0;
        end else if (!strap_taken && state == hrs_pkg::HRS_RECOVER && count == 32'd2) begin
            strap_taken <= 1'b1;
            pol_high    <= pol_s;
            led_strap   <= (sel_s == hrs_pkg::SEL_DEFAULT) ? led_s : '0;
            if (sel_s == hrs_pkg::SEL_STRAP) cfg_source <= hrs_pkg::SRC_STRAP;
            else if (sel_s == hrs_pkg::SEL_SMBUS)
                cfg_source <= smbus_disable ? hrs_pkg::SRC_SMBUS : hrs_pkg::SRC_EEPROM;
            else cfg_source <= hrs_pkg::SRC_DEFAULT;
        end
    end

    // Clock, transceiver and LED enables stay off while reset is held. [RULE3] [RULE6]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_enable     <= 1'b0;
            pll_enable     <= 1'b0;
            phy_enable     <= 1'b0;
            led_enable     <= 1'b0;
            outputs_driven <= 1'b0;
            operational    <= 1'b0;
        end else begin
            osc_enable     <= 1'b1;
            pll_enable     <= 1'b1;
            outputs_driven <= 1'b1; // [RULE9]
            operational    <= operational || (state == hrs_pkg::HRS_RECOVER && recover_end);
            phy_enable     <= (state == hrs_pkg::HRS_RUN);
            led_enable     <= (state == hrs_pkg::HRS_RUN);
        end
    end

    // Ports and port power, with the polarity strap applied. [RULE2] [RULE16] [RULE19]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_enable      <= '0;
            port_power_out   <= '0;
            downstream_reset <= 1'b0;
        end else begin
            port_enable      <= ports_on ? {hrs_pkg::NUM_PORTS{1'b1}} : '0;
            port_power_out   <= pol_high ? pwr_active : ~pwr_active; // [RULE20]
            downstream_reset <= 1'b0;
        end
    end

    // Configuration load starts and attach. [RULE8] [RULE10] [RULE25]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eeprom_read_start <= 1'b0;
            smbus_load_start  <= 1'b0;
            attach            <= 1'b0;
            load_timeout      <= 1'b0;
        end else begin
            eeprom_read_start <= (state == hrs_pkg::HRS_RECOVER) && recover_end && use_eeprom;
            smbus_load_start  <= (state == hrs_pkg::HRS_RECOVER) && recover_end && use_smbus;
            load_timeout      <= load_timeout || (state == hrs_pkg::HRS_LOAD && load_expire && !done_s);
            attach            <= attach || (state == hrs_pkg::HRS_APPLY); // [RULE12]
        end
    end

    // Bus reset: address, configuration, translator buffers, suspend. [RULE15] [RULE17] [RULE18]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_addr   <= hrs_pkg::ADDR_RESET;
            configured <= 1'b0;
            tt_flush   <= 1'b0;
            suspended  <= 1'b0;
        end else begin
            tt_flush <= brst_s;
            if (brst_s) begin
                dev_addr   <= hrs_pkg::ADDR_RESET;
                configured <= 1'b0;
                suspended  <= 1'b0;
            end else begin
                configured <= configured || (state == hrs_pkg::HRS_RUN);
                suspended  <= susp_s && (state == hrs_pkg::HRS_RUN);
            end
        end
    end

    // Request watchdog; a request left open past the limit is flagged. [RULE14]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_busy    <= 1'b0;
            req_count   <= '0;
            req_timeout <= 1'b0;
        end else begin
            if (req_done || brst_s) req_busy <= 1'b0;
            else if (req_start && state == hrs_pkg::HRS_RUN) req_busy <= 1'b1;
            req_count   <= req_busy ? req_count + 32'd1 : '0;
            req_timeout <= req_busy && (req_count >= REQ_MAX_CYC - 1);
        end
    end

    // XNOR chain result in continuity test. [RULE23]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) chain_result_out <= 1'b0;
        else chain_result_out <= (state == hrs_pkg::HRS_TEST) ? chain_xnor : 1'b0;
    end

    a_power_reset_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE16]
        brst_s |-> ##2 (port_power_out == (pol_high ? 4'h0 : 4'hf)))
        else $error("port power not removed after bus reset");
    a_addr_reset_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE15]
        brst_s |=> (dev_addr == 7'h00 && !configured))
        else $error("address not cleared on bus reset");
    a_tt_flush_follows: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE17]
        brst_s |=> tt_flush)
        else $error("translator buffers not flushed");
    a_suspend_leave: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE18]
        brst_s |=> !suspended)
        else $error("still suspended after bus reset");
    a_no_forward_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE19]
        !downstream_reset)
        else $error("bus reset forwarded downstream");
    a_attach_after_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE25]
        $rose(attach) |-> $past(state) == hrs_pkg::HRS_APPLY)
        else $error("attach without finished load");
    a_phases_in_order: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
        (state == hrs_pkg::HRS_LOAD) |-> operational)
        else $error("load begun before recovery ended");
    a_chain_in_test: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE23]
        (state != hrs_pkg::HRS_TEST) |=> !chain_result_out)
        else $error("chain output active outside test");
    a_leds_off_early: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
        (state == hrs_pkg::HRS_RECOVER) |=> !led_enable && !phy_enable)
        else $error("leds or phy enabled before running");
    a_ports_off_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
        (state != hrs_pkg::HRS_RUN) |=> (port_enable == '0))
        else $error("ports enabled before running");
    a_eeprom_load_bound: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE10]
        (state == hrs_pkg::HRS_LOAD && cfg_source == hrs_pkg::SRC_EEPROM) |->
        (count < EEPROM_MAX_CYC))
        else $error("eeprom load overran its limit");
    a_req_overdue_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE14]
        (req_busy && req_count >= REQ_MAX_CYC) |-> req_timeout)
        else $error("overdue request not flagged");
    a_test_no_attach: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE22]
        (state == hrs_pkg::HRS_TEST) |-> (!attach && !operational))
        else $error("attach or operation in test mode");
endmodule

// file: verif/hrs_host_model.sv
`timescale 1ns/1ns
module hrs_host_model #(
    parameter int LOAD_DLY  = 30,
    parameter int HOST_WAIT = 40
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Device side.
    input  wire logic eeprom_read_start,
    input  wire logic smbus_load_start,
    input  wire logic attach,
    // Bench controls.
    input  wire logic answer,
    input  wire logic reset_go,
    // Answers.
    output logic      load_done,
    output logic      bus_reset
);
    int   load_cnt;
    int   att_cnt;
    logic busy;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_cnt  <= 0;
            att_cnt   <= 0;
            busy      <= 1'b0;
            load_done <= 1'b0;
            bus_reset <= 1'b0;
        end else begin
            if (eeprom_read_start || smbus_load_start) begin
                busy <= 1'b1;
            end
            if (busy && answer && load_cnt < LOAD_DLY) begin
                load_cnt <= load_cnt + 1;
            end
            load_done <= (load_cnt == LOAD_DLY);
            if (attach && att_cnt < HOST_WAIT) begin
                att_cnt <= att_cnt + 1;
            end
            // The host holds off bus reset until attach has stood long enough.
            bus_reset <= reset_go && (att_cnt == HOST_WAIT);
        end
    end
endmodule

// file: verif/test_hrs_sequencer.sv
`timescale 1ns/1ns
module test_hrs_sequencer;
    localparam int REC = 20;
    localparam int EEP = 200;
    localparam int REQ = 50;
    logic        ref_clk = 1'b0, rst_n = 1'b0, pol = 1'b1, test_mode_pin = 1'b0;
    logic        smb_clk_pin = 1'b1, smbus_disable = 1'b0, suspend_req = 1'b0;
    logic        req_start = 1'b0, req_done = 1'b0, answer = 1'b1, reset_go = 1'b0;
    logic [2:0]  cfg_sel_pin = 3'h0;
    logic [7:0]  led_pin = 8'h00;
    logic [15:0] test_pins = 16'h0000;
    logic [3:0]  port_power_req = 4'h0;
    logic        osc_enable, pll_enable, phy_enable, led_enable, outputs_driven;
    logic        downstream_reset, eeprom_read_start, smbus_load_start, attach;
    logic        operational, configured, tt_flush, suspended, load_timeout;
    logic        req_timeout, chain_result_out, load_done, bus_reset, c;
    logic [3:0]  port_enable, port_power_out;
    logic [1:0]  cfg_source;
    logic [7:0]  led_strap;
    logic [6:0]  dev_addr;
    int          err_count = 0;
    int          n_tests = 0;

    always #4 ref_clk = ~ref_clk;

    hrs_sequencer #(.RECOVERY_CYC(REC), .EEPROM_MAX_CYC(EEP), .REQ_MAX_CYC(REQ)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .cfg_sel_pin(cfg_sel_pin),
        .port_power_polarity_strap(pol), .test_mode_pin(test_mode_pin),
        .smb_clk_pin(smb_clk_pin), .smbus_disable(smbus_disable), .led_pin(led_pin),
        .test_pins(test_pins), .load_done(load_done), .port_power_req(port_power_req),
        .bus_reset(bus_reset), .suspend_req(suspend_req), .req_start(req_start),
        .req_done(req_done), .osc_enable(osc_enable), .pll_enable(pll_enable),
        .phy_enable(phy_enable), .led_enable(led_enable), .outputs_driven(outputs_driven),
        .port_enable(port_enable), .port_power_out(port_power_out),
        .downstream_reset(downstream_reset), .eeprom_read_start(eeprom_read_start),
        .smbus_load_start(smbus_load_start), .cfg_source(cfg_source), .led_strap(led_strap),
        .attach(attach), .operational(operational), .configured(configured),
        .dev_addr(dev_addr), .tt_flush(tt_flush), .suspended(suspended),
        .load_timeout(load_timeout), .req_timeout(req_timeout),
        .chain_result_out(chain_result_out));

    hrs_host_model host (
        .ref_clk(ref_clk), .rst_n(rst_n), .eeprom_read_start(eeprom_read_start),
        .smbus_load_start(smbus_load_start), .attach(attach), .answer(answer),
        .reset_go(reset_go), .load_done(load_done), .bus_reset(bus_reset));

    task automatic summarize();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    function automatic logic pick(input int w);
        logic [8:0] s;
        s = {load_timeout, smbus_load_start, eeprom_read_start, req_timeout, tt_flush,
             suspended, attach, operational, outputs_driven};
        return s[w];
    endfunction

    // Waits for one watched output; running out of the bound ends the run.
    task automatic wait_on(input int w, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(posedge ref_clk);
            #1;
            if (pick(w) === 1'b1) begin
                return;
            end
        end
        err_count++;
        $display("MISMATCH t=%0t wait %0d timed out", $time, w);
        summarize();
    endtask

    task automatic boot(input logic [2:0] sel, input logic p, input logic dis, input logic t);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cfg_sel_pin <= sel;
        pol <= p;
        smbus_disable <= dis;
        test_mode_pin <= t;
        smb_clk_pin <= ~t;
        repeat (6) @(posedge ref_clk);
        #1;
        chk({port_enable, port_power_out}, 8'h00, "ports live in reset");
        chk({osc_enable, pll_enable, led_enable, phy_enable}, 8'h00, "clocks on");
        chk({attach, dev_addr}, 8'h00, "state kept in reset");
        @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask

    initial begin
        led_pin <= 8'ha5;
        port_power_req <= 4'h5;
        boot(hrs_pkg::SEL_DEFAULT, 1'b1, 1'b0, 1'b0);
        wait_on(0, hrs_pkg::INACTIVE_CYC);
        wait_on(1, REC + 10);
        wait_on(2, 20);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(operational, 1'b1, "attach before ready");
        chk({osc_enable, pll_enable, port_enable}, 8'h3f, "run clocks or ports");
        chk(led_strap, 8'ha5, "led straps");
        chk(cfg_source, hrs_pkg::SRC_DEFAULT, "source default");
        chk({phy_enable, led_enable}, 2'h3, "run enables");
        chk(port_power_out, 4'h5, "power high pol");
        @(posedge ref_clk);
        req_start <= 1'b1;
        @(posedge ref_clk);
        req_start <= 1'b0;
        req_done <= 1'b1;
        @(posedge ref_clk);
        req_done <= 1'b0;
        repeat (REQ + 5) @(posedge ref_clk);
        #1;
        chk(req_timeout, 1'b0, "answered request overdue");
        @(posedge ref_clk);
        req_start <= 1'b1;
        @(posedge ref_clk);
        req_start <= 1'b0;
        wait_on(5, REQ + 10);
        @(posedge ref_clk);
        suspend_req <= 1'b1;
        wait_on(3, 10);
        @(posedge ref_clk);
        reset_go <= 1'b1;
        wait_on(4, 60);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(dev_addr, hrs_pkg::ADDR_RESET, "address kept");
        chk({configured, suspended}, 2'h0, "still configured or suspended");
        chk({downstream_reset, port_power_out}, 8'h00, "bus reset power");
        reset_go <= 1'b0;
        suspend_req <= 1'b0;
        boot(hrs_pkg::SEL_SMBUS, 1'b0, 1'b0, 1'b0);
        wait_on(6, REC + 10);
        chk({cfg_source, attach}, {hrs_pkg::SRC_EEPROM, 1'b0}, "eeprom source");
        chk(port_power_out, 4'hf, "low pol off");
        wait_on(2, 50);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(load_done, 1'b1, "attach before load");
        chk(port_power_out, 4'ha, "power low pol");
        boot(hrs_pkg::SEL_SMBUS, 1'b1, 1'b1, 1'b0);
        wait_on(7, REC + 10);
        chk(cfg_source, hrs_pkg::SRC_SMBUS, "smbus source");
        wait_on(2, 50);
        answer <= 1'b0;
        boot(hrs_pkg::SEL_SMBUS, 1'b1, 1'b0, 1'b0);
        wait_on(8, REC + EEP + 10);
        wait_on(2, 10);
        answer <= 1'b1;
        boot(hrs_pkg::SEL_STRAP, 1'b1, 1'b0, 1'b0);
        wait_on(2, REC + 20);
        chk(cfg_source, hrs_pkg::SRC_STRAP, "strap source");
        boot(3'h2, 1'b1, 1'b0, 1'b1);
        repeat (REC + 10) @(posedge ref_clk);
        #1;
        c = chain_result_out;
        chk({attach, operational}, 2'h0, "test mode left");
        @(posedge ref_clk);
        test_pins <= 16'h0008;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(chain_result_out, {7'h00, ~c}, "chain no toggle");
        summarize();
    end
endmodule
